// ---- test/temperature_result_registers_tb.sv ----
module temperature_result_registers_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tres_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        slv_err;
	logic        irq;
	logic        meas_tick;
	tres_meas_t  meas_in;
	logic [15:0] exp_q [4] = '{16'h7FFA, 16'h8005, 16'hFFFF, 16'h0100};
	int          err_count = 0;
	int          cmp_count = 0;
	int          n;

	tres_regs #(.TICK_CYCLES(20)) i_tres_regs (.ref_clk(ref_clk), .reset_n(reset_n),
		.meas_in(meas_in), .meas_tick(meas_tick), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	tres_engine_model i_tres_engine_model (.ref_clk(ref_clk), .reset_n(reset_n),
		.meas_tick(meas_tick), .meas_in(meas_in));

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		cmp_count++;
		if (seen !== expv)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		logic got;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		slv_err = pslverr;
		got = (pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never re-drives psel in this time step
		@(posedge ref_clk);
		if (!got)
		begin
			err_count++;
			give_verdict();
		end
	endtask

	task automatic wait_tick();
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end while (meas_tick !== 1'b1 && n < 100);
		if (meas_tick !== 1'b1)
		begin
			err_count++;
			give_verdict();
		end
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, TRES_ADDR_FRAC, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, TRES_ADDR_INT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, TRES_ADDR_IRQ_MASK, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		for (int k = 0; k < 4; k++)
		begin
			wait_tick();
			apb(1'b1, TRES_ADDR_INT, 32'hFF);
			apb(1'b0, TRES_ADDR_INT, 32'h0);
			chk(rd, {24'h0, exp_q[k][15:8]});
			apb(1'b0, TRES_ADDR_FRAC, 32'h0);
			chk(rd, {24'h0, exp_q[k][7:0]});
		end
		$display("result test done");
		apb(1'b0, TRES_ADDR_INT, 32'h0);
		chk(rd, {24'h0, exp_q[3][15:8]});
		wait_tick();
		apb(1'b0, TRES_ADDR_FRAC, 32'h0);
		chk(rd, {24'h0, exp_q[0][7:0]});
		$display("torn read test done");
		wait_tick();
		apb(1'b0, TRES_ADDR_IRQ_STAT, 32'h0);
		chk(rd, 32'h3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, TRES_ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, TRES_ADDR_IRQ_STAT, 32'h3);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, slv_err}, 32'h1);
		chk(rd, 32'h0);
		wait_tick();
		chk({31'h0, irq}, 32'h1);
		$display("interrupt test done");
		give_verdict();
	end
endmodule

// ---- test/tres_engine_model.sv ----
module tres_engine_model (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	// result side
	input  wire logic                 meas_tick,
	output tres_pkg::tres_meas_t      meas_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import tres_pkg::*;
	// code and flags per tick, flags differ each time
	logic [15:0] code_list [4] = '{16'h7FFA, 16'h8005, 16'hFFFF, 16'h0100};
	logic [1:0]  idx;
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			idx <= 2'h0;
		else if (meas_tick)
			idx <= idx + 2'h1;
	end
	assign meas_in = tres_meas_t'(code_list[idx]);
endmodule

// ---- verilog/tres_pkg.sv ----
package tres_pkg;

	// register index and byte address, one word per index
	localparam logic [7:0]  TRES_IDX_FRAC      = 8'h0E;
	localparam logic [7:0]  TRES_IDX_INT       = 8'h0F;
	localparam logic [11:0] TRES_ADDR_FRAC     = {2'h0, TRES_IDX_FRAC, 2'h0};
	localparam logic [11:0] TRES_ADDR_INT      = {2'h0, TRES_IDX_INT, 2'h0};
	localparam logic [11:0] TRES_ADDR_IRQ_STAT = 12'h040;
	localparam logic [11:0] TRES_ADDR_IRQ_MASK = 12'h044;

	// low byte field positions
	localparam int TRES_POS_MEM_FAIL   = 3;
	localparam int TRES_POS_MEM_BUSY   = 2;
	localparam int TRES_POS_CLK_OUT    = 1;
	localparam int TRES_POS_SWITCHOVER = 0;

	// interrupt status bit positions
	localparam int TRES_IRQ_POS_UPDATE = 0;
	localparam int TRES_IRQ_POS_FLAGS  = 1;

	// reset values
	localparam logic [11:0] TRES_TEMP_RESET = 12'h000;
	localparam logic [1:0]  TRES_IRQ_RESET  = 2'h0;
	localparam logic [1:0]  TRES_MASK_RESET = 2'h0;

	// timing: 1 s tick at 100 MHz
	localparam longint TRES_CLK_HZ      = 100000000;
	localparam longint TRES_TICK_S      = 1;
	localparam int     TRES_TICK_CYCLES = int'(TRES_CLK_HZ * TRES_TICK_S);

	typedef struct packed {
		logic memory_fail_flag;
		logic memory_busy_flag;
		logic clock_output_flag;
		logic supply_switchover_flag;
	} tres_flags_t;

	typedef struct packed {
		logic [11:0] code;
		tres_flags_t flags;
	} tres_meas_t;

endpackage

// ---- verilog/tres_regs.sv ----
// Functional notes
// - temperature is 12-bit two's complement code, degrees are signed value over 16
// - low byte: fraction bits 7:4, memory fail, busy, clock out, switchover in 3:0
// - high byte is read-only: sign in bit 7, integer weights in 6:0
// - code reads all zeros after reset until the first measurement
// - both bytes update directly, no shadow or read latching
// - writes to the high byte are ignored
//
// Implementation choice: the APB register port.
module tres_regs #(
	parameter int TICK_CYCLES = tres_pkg::TRES_TICK_CYCLES
) (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	// measurement engine
	input  wire tres_pkg::tres_meas_t meas_in,
	output logic                     meas_tick,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// interrupt
	output logic                     irq
);
	import tres_pkg::*;

	logic        tick;
	logic [11:0] code;
	tres_flags_t flags;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic [11:0] next_code;
	tres_flags_t next_flags;
	logic [1:0]  next_irq_stat;
	logic [1:0]  next_irq_mask;
	logic        next_irq;
	logic        access;
	logic        wr;

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == TRES_ADDR_FRAC) || (a == TRES_ADDR_INT)
			|| (a == TRES_ADDR_IRQ_STAT) || (a == TRES_ADDR_IRQ_MASK);
	endfunction

	tres_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.tick   (tick)
	);

	// one access cycle, answer in setup+1: pready registered high for one cycle
	assign access = psel && !penable;
	assign wr     = psel && penable && pready && pwrite;

	always_comb
	begin
		next_code     = code;
		next_flags    = flags;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		next_prdata   = 32'h00000000;
		next_pslverr  = 1'b0;
		if (tick)
		begin
			next_code  = meas_in.code;
			next_flags = meas_in.flags;
		end
		// write-one-to-clear, set wins
		if (wr && paddr == TRES_ADDR_IRQ_STAT && pstrb[0])
			next_irq_stat = irq_stat & ~pwdata[1:0];
		if (wr && paddr == TRES_ADDR_IRQ_MASK && pstrb[0])
			next_irq_mask = pwdata[1:0];
		if (tick)
		begin
			next_irq_stat[TRES_IRQ_POS_UPDATE] = 1'b1;
			if (meas_in.flags != flags)
				next_irq_stat[TRES_IRQ_POS_FLAGS] = 1'b1;
		end
		// writes to both temperature bytes leave them unchanged
		if (access)
		begin
			next_pslverr = !addr_known(paddr);
			case (paddr)
				TRES_ADDR_FRAC:     next_prdata = {24'h000000, code[3:0], flags};
				TRES_ADDR_INT:      next_prdata = {24'h000000, code[11:4]};
				TRES_ADDR_IRQ_STAT: next_prdata = {30'h00000000, irq_stat};
				TRES_ADDR_IRQ_MASK: next_prdata = {30'h00000000, irq_mask};
				default:            next_prdata = 32'h00000000;
			endcase
		end
		else
			next_prdata = prdata;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			code      <= TRES_TEMP_RESET;
			flags     <= '0;
			irq_stat  <= TRES_IRQ_RESET;
			irq_mask  <= TRES_MASK_RESET;
			prdata    <= 32'h00000000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			irq       <= 1'b0;
			meas_tick <= 1'b0;
		end
		else
		begin
			code      <= next_code;
			flags     <= next_flags;
			irq_stat  <= next_irq_stat;
			irq_mask  <= next_irq_mask;
			prdata    <= next_prdata;
			pready    <= access;
			pslverr   <= access ? next_pslverr : 1'b0;
			irq       <= next_irq;
			meas_tick <= tick;
		end
	end

	// cycles since the last tick, minus one at reset so the first period counts alike
	int unsigned tick_gap;
	int unsigned next_tick_gap;

	always_comb
	begin
		next_tick_gap = tick_gap + 1;
		if (tick)
			next_tick_gap = 0;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			tick_gap <= 32'hFFFFFFFF;
		else
			tick_gap <= next_tick_gap;
	end

	// load, hold, read, reset, tick period and update interrupt checks
	sequence tick_seen;
		tick;
	endsequence

	sequence load_done;
		##1 (code == $past(meas_in.code) && flags == $past(meas_in.flags));
	endsequence

	load_on_tick_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick_seen |-> load_done)
		else $error("result not loaded on tick");

	hold_between_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!tick |=> $stable(code))
		else $error("code changed without tick");

	tick_period_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick |-> tick_gap == TICK_CYCLES - 1)
		else $error("tick period wrong");

	int_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(access && paddr == TRES_ADDR_INT && !tick) |=> prdata == {24'h000000, code[11:4]})
		else $error("high byte read wrong");

	frac_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(access && paddr == TRES_ADDR_FRAC && !tick)
		|=> prdata == {24'h000000, code[3:0], flags})
		else $error("low byte read wrong");

	write_ignored_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(wr && paddr == TRES_ADDR_INT && !tick) |=> $stable(code))
		else $error("write changed high byte");

	zero_before_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(reset_n) |-> code == TRES_TEMP_RESET)
		else $error("code not zero after reset");

	sign_bit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(access && paddr == TRES_ADDR_INT && !tick) |=> prdata[7] == code[11])
		else $error("sign bit misplaced");

	irq_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick ##1 irq_mask[TRES_IRQ_POS_UPDATE] |-> irq)
		else $error("update interrupt missing");

	// register bus and interrupt checks
	sequence err_answer;
		##1 (pready && pslverr && prdata == 32'h00000000);
	endsequence

	unknown_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(access && !addr_known(paddr)) |-> err_answer)
		else $error("unmapped address not refused");

	ready_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pready |=> !pready)
		else $error("ready held too long");

	err_with_ready_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pslverr |-> pready)
		else $error("error without ready");

	update_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick |=> irq_stat[TRES_IRQ_POS_UPDATE])
		else $error("update status not set");

	mask_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(wr && paddr == TRES_ADDR_IRQ_MASK && pstrb[0]) |=> irq_mask == $past(pwdata[1:0]))
		else $error("mask write lost");

endmodule

// ---- verilog/tres_tick.sv ----
module tres_tick #(
	parameter int TICK_CYCLES = tres_pkg::TRES_TICK_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// one-cycle timebase pulse
	output logic      tick
);
	import tres_pkg::*;

	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_tick;

	always_comb
	begin
		next_tick  = 1'b0;
		next_count = count + 32'h00000001;
		if (count >= 32'(TICK_CYCLES - 1))
		begin
			next_count = 32'h00000000;
			next_tick  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count <= 32'h00000000;
			tick  <= 1'b0;
		end
		else
		begin
			count <= next_count;
			tick  <= next_tick;
		end
	end

endmodule
